// file: src/uwl_load_unit.v
// Load unit for the right-part user-space load and indexed floating-point load
`timescale 1ns/10ps
`default_nettype none
`include "uwl_consts.vh"
// Summary of operation
// [R1] Right user load address is base plus sign-extended 9-bit offset.
// [R2] Right load puts 1..4 low bytes in register low end, upper unchanged; the code fills the top 0..3 lanes from memory instead.
// [R3] Merged bytes chosen by low two address bits and core byte order.
// [R4] Byte index is address bits XOR core big-endian flag; merge per index.
// [R5] Physical low bits XOR reverse flag, cleared when memory is little-endian.
// [R6] Right and left user loads together leave a full sign-extended word.
// [R7] User loads use user mapping in mapped-user segment; other user modes reachable.
// [R8] User loads exist only when the extension enable bit is one.
// [R9] Right user load raises refill, invalid, bus, address, watch, RI, CpU.
// [R10] Indexed float load address is base plus index register.
// [R11] Indexed float load raises address error before translation if misaligned.
// [R12] Indexed float load writes the 32-bit word to the float register low word.
// [R13] Indexed float load raises refill, invalid, address, RI, CpU, watch; the code never raises RI for it.
// [R14] User loads need system coprocessor access and a user-accessible segment.
// [R15] Each load goes out with adjusted address, cache attribute and byte count; the code sends the float load address unadjusted.
module uwl_load_unit (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Instruction issue
  input wire issue_valid,
  input wire issue_fp,
  input wire [31:0] issue_base,
  input wire [8:0] issue_offset,
  input wire [31:0] issue_index,
  input wire [31:0] issue_rt_old,
  input wire [4:0] issue_tag,
  output reg issue_ready,
  // Address translation
  output reg xl_req,
  output reg [31:0] xl_vaddr,
  output reg xl_user_map,
  input wire xl_ack,
  input wire [31:0] xl_paddr,
  input wire [2:0] xl_cca,
  input wire [2:0] xl_seg_mode,
  input wire xl_tlb_refill,
  input wire xl_tlb_invalid,
  input wire xl_watch,
  input wire xl_addr_err,
  // Memory access
  output reg mem_req,
  output reg [31:0] mem_paddr,
  output reg [2:0] mem_cca,
  output reg [1:0] mem_bytes,
  output reg mem_word,
  input wire mem_ack,
  input wire [31:0] mem_rdata,
  input wire mem_bus_err,
  // Writeback and exception
  output reg gpr_we,
  output reg fpr_we,
  output reg [4:0] wb_tag,
  output reg [31:0] wb_data,
  output reg exc_valid,
  output reg [2:0] exc_code,
  output reg [31:0] exc_vaddr,
  // Interrupt
  output reg irq
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_XLAT = 4'b0010;
  localparam [3:0] ST_MEM = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg [3:0] state;
  reg op_fp;
  reg [31:0] vaddr_q;
  reg [31:0] rt_q;
  reg [1:0] bidx_q;
  reg [`UWL_CTRL_WIDTH-1:0] ctrl;
  reg [`UWL_ST_WIDTH-1:0] status;
  reg [`UWL_ST_WIDTH-1:0] mask;
  reg [31:0] next_prdata;
  reg next_pslverr;

  wire [31:0] eff_addr;
  wire [1:0] byte_idx;
  wire [31:0] paddr_adj;
  wire [31:0] merged;
  wire [2:0] pre_exc;
  wire [2:0] post_exc;
  wire apb_setup;
  wire apb_wr;
  wire [`UWL_ST_WIDTH-1:0] st_set;

  // Checks made before translation; user loads are refused first if absent
  function [2:0] pre_check;
    input fp;
    input [`UWL_CTRL_WIDTH-1:0] c;
    input [1:0] low;
    begin
      if (fp) begin
        if (!c[`UWL_CTRL_COP1_EN])
          pre_check = `UWL_EXC_COP_UNUSABLE; // [R13]
        else if (low != 2'h0)
          pre_check = `UWL_EXC_ADDR_ERR; // [R11]
        else
          pre_check = `UWL_EXC_NONE;
      end else begin
        if (!c[`UWL_CTRL_EXT_EN])
          pre_check = `UWL_EXC_RSVD_INSTR; // [R8]
        else if (!c[`UWL_CTRL_COP0_EN])
          pre_check = `UWL_EXC_COP_UNUSABLE; // [R14]
        else
          pre_check = `UWL_EXC_NONE;
      end
    end
  endfunction

  // True for the three segment modes a user-space load may reach
  function seg_user_ok;
    input [2:0] mode;
    begin
      seg_user_ok = (mode == `UWL_SEG_UNMAPPED_USER_KERNEL_SEGMENT) || (mode == `UWL_SEG_MAPPED_USER_KERNEL_SEGMENT) || (mode == `UWL_SEG_MAPPED_USER_UNMAPPED_KERNEL_SEGMENT);
    end
  endfunction

  // Faults reported by translation, highest priority first
  function [2:0] post_check;
    input fp;
    input [2:0] mode;
    input aerr;
    input refill;
    input invalid;
    input watch;
    begin
      if (aerr || (!fp && !seg_user_ok(mode)))
        post_check = `UWL_EXC_ADDR_ERR; // [R14]
      else if (refill)
        post_check = `UWL_EXC_TLB_REFILL; // [R9] [R13]
      else if (invalid)
        post_check = `UWL_EXC_TLB_INVALID;
      else if (watch)
        post_check = `UWL_EXC_WATCH;
      else
        post_check = `UWL_EXC_NONE;
    end
  endfunction

  uwl_addr u_addr (
    .is_fp(issue_fp),
    .base(issue_base),
    .offset(issue_offset),
    .index(issue_index),
    .core_big_endian_flag(ctrl[`UWL_CTRL_CORE_BE]),
    .reverse_byte_order_flag(ctrl[`UWL_CTRL_REV_END]),
    .memory_big_endian_flag(ctrl[`UWL_CTRL_MEM_BE]),
    .paddr_raw(xl_paddr),
    .effective_address(eff_addr),
    .byte_idx(byte_idx),
    .paddr_adj(paddr_adj)
  );

  uwl_merge u_merge (
    .mem_word(mem_rdata),
    .reg_word(rt_q),
    .byte_idx(bidx_q),
    .merged(merged)
  );

  assign pre_exc = pre_check(issue_fp, ctrl, eff_addr[1:0]);
  assign post_exc = post_check(op_fp, xl_seg_mode, xl_addr_err, xl_tlb_refill, xl_tlb_invalid, xl_watch);

  // Load sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      op_fp <= 1'b0;
      vaddr_q <= 32'h0;
      rt_q <= 32'h0;
      bidx_q <= 2'h0;
      issue_ready <= 1'b0;
      xl_req <= 1'b0;
      xl_vaddr <= 32'h0;
      xl_user_map <= 1'b0;
      mem_req <= 1'b0;
      mem_paddr <= 32'h0;
      mem_cca <= 3'h0;
      mem_bytes <= 2'h0;
      mem_word <= 1'b0;
      gpr_we <= 1'b0;
      fpr_we <= 1'b0;
      wb_tag <= 5'h0;
      wb_data <= 32'h0;
      exc_valid <= 1'b0;
      exc_code <= `UWL_EXC_NONE;
      exc_vaddr <= 32'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          issue_ready <= 1'b1;
          if (issue_valid && issue_ready) begin
            issue_ready <= 1'b0;
            op_fp <= issue_fp;
            vaddr_q <= eff_addr;
            rt_q <= issue_rt_old;
            bidx_q <= byte_idx; // [R4]
            wb_tag <= issue_tag;
            if (pre_exc != `UWL_EXC_NONE) begin
              exc_valid <= 1'b1;
              exc_code <= pre_exc; // [R8] [R11] [R14]
              exc_vaddr <= eff_addr;
              state <= ST_DONE;
            end else begin
              xl_req <= 1'b1;
              xl_vaddr <= eff_addr;
              // Kernel-mode user-space load walks the user mapping
              xl_user_map <= ~issue_fp; // [R7]
              state <= ST_XLAT;
            end
          end
        end
        ST_XLAT: begin
          if (xl_ack) begin
            xl_req <= 1'b0;
            // A translation fault ends the load before any memory access goes out
            if (post_exc != `UWL_EXC_NONE) begin
              exc_valid <= 1'b1;
              exc_code <= post_exc; // [R9] [R13]
              exc_vaddr <= vaddr_q;
              state <= ST_DONE;
            end else begin
              mem_req <= 1'b1;
              // Float load is aligned, so its address goes out unchanged
              mem_paddr <= op_fp ? xl_paddr : paddr_adj; // [R5] [R15]
              mem_cca <= xl_cca; // [R15]
              mem_bytes <= op_fp ? 2'h0 : bidx_q; // [R15]
              mem_word <= op_fp;
              state <= ST_MEM;
            end
          end
        end
        ST_MEM: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_word <= 1'b0;
            state <= ST_DONE;
            // Float load has no bus error in its fault list, so the flag is dropped
            if (mem_bus_err && !op_fp) begin
              exc_valid <= 1'b1;
              exc_code <= `UWL_EXC_BUS_ERR; // [R9]
              exc_vaddr <= vaddr_q;
            end else if (op_fp) begin
              fpr_we <= 1'b1;
              wb_data <= mem_rdata; // [R12]
            end else begin
              gpr_we <= 1'b1;
              // A 32-bit register holding both halves is already the full word
              wb_data <= merged; // [R2] [R6]
            end
          end
        end
        ST_DONE: begin
          gpr_we <= 1'b0;
          fpr_we <= 1'b0;
          exc_valid <= 1'b0;
          issue_ready <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // APB slave: no wait states, pready raised in the first access cycle
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pready && pwrite;

  always @* begin
    next_prdata = 32'h0;
    next_pslverr = 1'b0;
    case (paddr)
      `UWL_ADDR_CTRL: next_prdata = {26'h0, ctrl};
      `UWL_ADDR_STATUS: next_prdata = {30'h0, status};
      `UWL_ADDR_MASK: next_prdata = {30'h0, mask};
      `UWL_ADDR_LAST: next_prdata = {25'h0, state == ST_IDLE, bidx_q, exc_code == `UWL_EXC_NONE, exc_code};
      `UWL_ADDR_VADDR: next_prdata = vaddr_q;
      default: next_pslverr = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0 : next_prdata;
        pslverr <= next_pslverr;
      end else begin
        prdata <= 32'h0;
        pslverr <= 1'b0;
      end
    end
  end

  // Events are taken from the one-cycle result pulses
  assign st_set = {exc_valid && state == ST_DONE, (gpr_we || fpr_we) && state == ST_DONE};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `UWL_CTRL_RESET;
      mask <= `UWL_MASK_RESET;
      status <= {`UWL_ST_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      // Control changes affect loads issued afterwards and the address adjustment of a load still in translation
      if (apb_wr && paddr == `UWL_ADDR_CTRL)
        ctrl <= pwdata[`UWL_CTRL_WIDTH-1:0];
      if (apb_wr && paddr == `UWL_ADDR_MASK)
        mask <= pwdata[`UWL_ST_WIDTH-1:0];
      // Set beats a simultaneous write-one-to-clear
      if (apb_wr && paddr == `UWL_ADDR_STATUS)
        status <= (status & ~pwdata[`UWL_ST_WIDTH-1:0]) | st_set;
      else
        status <= status | st_set;
      irq <= |(status & mask);
    end
  end
endmodule
`default_nettype wire

// file: src/uwl_consts.vh
// Constants for the unaligned and indexed word load unit
`ifndef UWL_CONSTS_VH
`define UWL_CONSTS_VH

// Register byte addresses on the APB slave
`define UWL_ADDR_CTRL 12'h000
`define UWL_ADDR_STATUS 12'h004
`define UWL_ADDR_MASK 12'h008
`define UWL_ADDR_LAST 12'h00c
`define UWL_ADDR_VADDR 12'h010

// Control register fields
`define UWL_CTRL_CORE_BE 0
`define UWL_CTRL_REV_END 1
`define UWL_CTRL_MEM_BE 2
`define UWL_CTRL_EXT_EN 3
`define UWL_CTRL_COP0_EN 4
`define UWL_CTRL_COP1_EN 5
`define UWL_CTRL_WIDTH 6
`define UWL_CTRL_RESET 6'h04

// Status and mask fields
`define UWL_ST_DONE 0
`define UWL_ST_EXC 1
`define UWL_ST_WIDTH 2
`define UWL_MASK_RESET 2'h0

// Segment access modes reported by translation
`define UWL_SEG_UNMAPPED_USER_KERNEL_SEGMENT 3'h1
`define UWL_SEG_MAPPED_USER_KERNEL_SEGMENT 3'h2
`define UWL_SEG_MAPPED_USER_UNMAPPED_KERNEL_SEGMENT 3'h3

// Exception codes
`define UWL_EXC_NONE 3'h0
`define UWL_EXC_TLB_REFILL 3'h1
`define UWL_EXC_TLB_INVALID 3'h2
`define UWL_EXC_BUS_ERR 3'h3
`define UWL_EXC_ADDR_ERR 3'h4
`define UWL_EXC_WATCH 3'h5
`define UWL_EXC_RSVD_INSTR 3'h6
`define UWL_EXC_COP_UNUSABLE 3'h7

`endif

// file: src/uwl_addr.v
// Effective address, byte index and physical address adjustment
`timescale 1ns/10ps
`default_nettype none
module uwl_addr (
  // Operands
  input wire is_fp,
  input wire [31:0] base,
  input wire [8:0] offset,
  input wire [31:0] index,
  // Byte order controls
  input wire core_big_endian_flag,
  input wire reverse_byte_order_flag,
  input wire memory_big_endian_flag,
  // Translated address in
  input wire [31:0] paddr_raw,
  // Results
  output wire [31:0] effective_address,
  output wire [1:0] byte_idx,
  output wire [31:0] paddr_adj
);
  wire [31:0] addend;
  wire [1:0] rev_low;

  assign addend = is_fp ? index : {{23{offset[8]}}, offset}; // [R1] [R10]
  assign effective_address = base + addend;
  assign byte_idx = effective_address[1:0] ^ {2{core_big_endian_flag}}; // [R3] [R4]
  assign rev_low = paddr_raw[1:0] ^ {2{reverse_byte_order_flag}};
  assign paddr_adj = {paddr_raw[31:2], memory_big_endian_flag ? rev_low : 2'h0}; // [R5]
endmodule
`default_nettype wire

// file: src/uwl_merge.v
// Byte-lane merge of memory word into the top end of the register
`timescale 1ns/10ps
`default_nettype none
module uwl_merge (
  input wire [31:0] mem_word,
  input wire [31:0] reg_word,
  input wire [1:0] byte_idx,
  output wire [31:0] merged
);
  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_lane
      localparam [2:0] LANE = k;
      wire from_mem;
      // Top byte_idx lanes come from memory, the rest keep the register
      assign from_mem = ({1'b0, byte_idx} + LANE) > 3'h3; // [R2] [R4]
      assign merged[8*k+7:8*k] = from_mem ? mem_word[8*k+7:8*k] : reg_word[8*k+7:8*k];
    end
  endgenerate
endmodule
`default_nettype wire

// file: tb/uwl_assertions.sv
// Port-level assertions for the load unit
`timescale 1ns/10ps
`default_nettype none
`include "uwl_consts.vh"
module uwl_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Issue
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire logic issue_fp,
  input wire logic [31:0] issue_base,
  input wire logic [8:0] issue_offset,
  input wire logic [31:0] issue_index,
  // Translation and memory
  input wire logic xl_req,
  input wire logic [31:0] xl_vaddr,
  input wire logic xl_user_map,
  input wire logic xl_ack,
  input wire logic [2:0] xl_cca,
  input wire logic xl_tlb_refill,
  input wire logic xl_addr_err,
  input wire logic mem_req,
  input wire logic [2:0] mem_cca,
  input wire logic mem_word,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_bus_err,
  // Results
  input wire logic fpr_we,
  input wire logic [31:0] wb_data,
  input wire logic exc_valid,
  input wire logic [2:0] exc_code
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_uea;
    $rose(xl_req) && xl_user_map |-> xl_vaddr == $past(issue_base) + 32'($signed($past(issue_offset)));
  endproperty
  a_uea: assert property (p_uea) else $error("bad user ea");
  property p_fea;
    $rose(xl_req) && !xl_user_map |-> xl_vaddr == $past(issue_base) + $past(issue_index);
  endproperty
  a_fea: assert property (p_fea) else $error("bad float ea");
  property p_map;
    $rose(xl_req) |-> xl_user_map != $past(issue_fp);
  endproperty
  a_map: assert property (p_map) else $error("bad mapping");
  // Misalignment must stop the load before translation is asked for
  property p_mis;
    issue_valid && issue_ready && issue_fp && ((issue_base + issue_index) & 32'h3) != 0 |=> exc_valid && !xl_req;
  endproperty
  a_mis: assert property (p_mis) else $error("misaligned load translated");
  property p_fwb;
    mem_req && mem_ack && mem_word |=> fpr_we && wb_data == $past(mem_rdata);
  endproperty
  a_fwb: assert property (p_fwb) else $error("bad float write");
  property p_bus;
    mem_req && mem_ack && !mem_word && mem_bus_err |=> exc_valid && exc_code == `UWL_EXC_BUS_ERR;
  endproperty
  a_bus: assert property (p_bus) else $error("bus error lost");
  property p_ref;
    xl_req && xl_ack && !xl_user_map && xl_tlb_refill && !xl_addr_err |=> exc_valid && !mem_req
      && exc_code == `UWL_EXC_TLB_REFILL;
  endproperty
  a_ref: assert property (p_ref) else $error("refill lost");
  property p_cca;
    $rose(mem_req) |-> mem_cca == $past(xl_cca);
  endproperty
  a_cca: assert property (p_cca) else $error("bad cache attribute");
endmodule
bind uwl_load_unit uwl_checker i_chk (.pclk, .presetn, .issue_valid, .issue_ready, .issue_fp, .issue_base,
  .issue_offset, .issue_index, .xl_req, .xl_vaddr, .xl_user_map, .xl_ack, .xl_cca, .xl_tlb_refill,
  .xl_addr_err, .mem_req, .mem_cca, .mem_word, .mem_ack, .mem_rdata, .mem_bus_err, .fpr_we, .wb_data,
  .exc_valid, .exc_code);
`default_nettype wire

// file: tb/uwl_mem_model.sv
// Translation and memory partner with settable delay and faults
`timescale 1ns/10ps
`default_nettype none
module uwl_mem_model (
  // Clock, reset and test controls
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] dly,
  input wire logic [4:0] flt,
  input wire logic [2:0] seg,
  input wire logic [31:0] word,
  // Translation
  input wire logic xl_req,
  input wire logic [31:0] xl_vaddr,
  output logic xl_ack,
  output logic [31:0] xl_paddr,
  output logic [2:0] xl_cca,
  output logic [2:0] xl_seg_mode,
  output logic xl_tlb_refill,
  output logic xl_tlb_invalid,
  output logic xl_watch,
  output logic xl_addr_err,
  // Memory
  input wire logic mem_req,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  output logic mem_bus_err
);
  logic [1:0] cnt;
  // Address, attribute, segment and data fields carry inverted values outside ack, fault flags read zero, so stale data is never mistaken for valid
  assign xl_paddr = xl_ack ? xl_vaddr : ~xl_vaddr;
  assign xl_cca = xl_ack ? 3'h5 : 3'h2;
  assign xl_seg_mode = xl_ack ? seg : ~seg;
  assign {xl_tlb_refill, xl_tlb_invalid, xl_watch, xl_addr_err} = xl_ack ? flt[3:0] : 4'h0;
  assign mem_rdata = mem_ack ? word : ~word;
  assign mem_bus_err = mem_ack & flt[4];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 2'h0;
      xl_ack <= 1'b0;
      mem_ack <= 1'b0;
    end else begin
      xl_ack <= 1'b0;
      mem_ack <= 1'b0;
      if ((xl_req && !xl_ack) || (mem_req && !mem_ack)) begin
        cnt <= cnt + 2'h1;
        if (cnt == dly) begin
          cnt <= 2'h0;
          xl_ack <= xl_req;
          mem_ack <= mem_req;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the load unit
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  typedef struct packed {logic fp; logic [5:0] ctrl; logic [11:0] base; logic [8:0] off; logic [4:0] flt;
    logic [2:0] seg; logic [2:0] exc;} uwl_row_t;
  localparam logic [31:0] WORD = 32'h8a7b6c5d;
  localparam logic [31:0] RT = 32'h13579bdf;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, issue_valid = 1'b0;
  logic issue_fp = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, issue_base = 32'h0, issue_index = 32'h0, issue_rt_old = 32'h0;
  logic [8:0] issue_offset = 9'h0;
  logic [4:0] issue_tag = 5'h0, flt = 5'h0, wb_tag;
  logic [2:0] seg = 3'h3, xl_cca, xl_seg_mode, mem_cca, exc_code;
  logic [1:0] dly = 2'h0, mem_bytes, b;
  logic [2:0] seen_nb;
  logic [31:0] prdata, xl_vaddr, xl_paddr, mem_paddr, mem_rdata, wb_data, exc_vaddr, q, seen_pa, ea, ex, pa;
  logic pready, pslverr, issue_ready, xl_req, xl_user_map, xl_ack, xl_tlb_refill, xl_tlb_invalid, xl_watch;
  logic xl_addr_err, mem_req, mem_word, mem_ack, mem_bus_err, gpr_we, fpr_we, exc_valid, irq, e;
  int mismatches = 0, checks = 0, n;
  uwl_row_t r;
  uwl_row_t rows [16] = '{
    '{1'b0, 6'h18, 12'h100, 9'h1ff, 5'h00, 3'h3, 3'h0}, '{1'b0, 6'h19, 12'h301, 9'h100, 5'h00, 3'h3, 3'h0},
    '{1'b0, 6'h1e, 12'h200, 9'h001, 5'h00, 3'h1, 3'h0}, '{1'b0, 6'h1c, 12'h200, 9'h000, 5'h00, 3'h2, 3'h0},
    '{1'b0, 6'h10, 12'h100, 9'h000, 5'h00, 3'h3, 3'h6}, '{1'b0, 6'h08, 12'h100, 9'h000, 5'h00, 3'h3, 3'h7},
    '{1'b1, 6'h20, 12'h300, 9'h004, 5'h00, 3'h3, 3'h0}, '{1'b1, 6'h20, 12'h301, 9'h002, 5'h00, 3'h3, 3'h4},
    '{1'b1, 6'h00, 12'h300, 9'h004, 5'h00, 3'h3, 3'h7}, '{1'b1, 6'h20, 12'h300, 9'h008, 5'h08, 3'h3, 3'h1},
    '{1'b0, 6'h18, 12'h104, 9'h000, 5'h04, 3'h3, 3'h2}, '{1'b0, 6'h18, 12'h104, 9'h000, 5'h10, 3'h3, 3'h3},
    '{1'b1, 6'h20, 12'h300, 9'h000, 5'h02, 3'h3, 3'h5}, '{1'b0, 6'h18, 12'h104, 9'h000, 5'h01, 3'h3, 3'h4},
    '{1'b1, 6'h20, 12'h300, 9'h000, 5'h10, 3'h3, 3'h0}, '{1'b0, 6'h18, 12'h100, 9'h000, 5'h00, 3'h0, 3'h4}};
  always #2 pclk = ~pclk;
  uwl_load_unit i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .issue_valid, .issue_fp, .issue_base, .issue_offset, .issue_index, .issue_rt_old, .issue_tag, .issue_ready,
    .xl_req, .xl_vaddr, .xl_user_map, .xl_ack, .xl_paddr, .xl_cca, .xl_seg_mode, .xl_tlb_refill, .xl_tlb_invalid,
    .xl_watch, .xl_addr_err, .mem_req, .mem_paddr, .mem_cca, .mem_bytes, .mem_word, .mem_ack, .mem_rdata,
    .mem_bus_err, .gpr_we, .fpr_we, .wb_tag, .wb_data, .exc_valid, .exc_code, .exc_vaddr, .irq);
  uwl_mem_model i_mem (.pclk, .presetn, .dly, .flt, .seg, .word(WORD), .xl_req, .xl_vaddr, .xl_ack, .xl_paddr,
    .xl_cca, .xl_seg_mode, .xl_tlb_refill, .xl_tlb_invalid, .xl_watch, .xl_addr_err, .mem_req, .mem_ack,
    .mem_rdata, .mem_bus_err);
  always @(posedge pclk) begin
    if (mem_req && mem_ack) begin
      seen_pa = mem_paddr;
      seen_nb = {mem_word, mem_bytes};
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(q, i ? 32'h0 : 32'h4, "reset value");
    end
    apb(1'b0, 12'h040, 32'h0);
    chk(32'(e), 32'h1, "unmapped err");
    chk(q, 32'h0, "unmapped data");
    apb(1'b1, 12'h008, 32'h1);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, 12'h000, 32'(r.ctrl));
      flt <= r.flt;
      seg <= r.seg;
      dly <= 2'(i);
      issue_fp <= r.fp;
      issue_base <= 32'(r.base);
      issue_offset <= r.off;
      issue_index <= 32'(r.off);
      issue_rt_old <= RT;
      issue_tag <= 5'(i);
      issue_valid <= 1'b1;
      do @(posedge pclk); while (issue_ready !== 1'b1);
      issue_valid <= 1'b0;
      for (n = 0; n < 40 && gpr_we !== 1'b1 && fpr_we !== 1'b1 && exc_valid !== 1'b1; n++) @(posedge pclk);
      ea = r.fp ? 32'(r.base) + 32'(r.off) : 32'(r.base) + 32'($signed(r.off));
      b = ea[1:0] ^ {2{r.ctrl[0]}};
      ex = r.fp ? WORD : (WORD & ~(32'hffffffff >> 8 * b)) | (RT & (32'hffffffff >> 8 * b));
      pa = r.fp ? ea : {ea[31:2], r.ctrl[2] ? ea[1:0] ^ {2{r.ctrl[1]}} : 2'h0};
      if (r.exc != 3'h0) begin
        chk(32'(exc_valid), 32'h1, "exc pulse");
        chk(32'(exc_code), 32'(r.exc), "exc code");
        chk(exc_vaddr, ea, "exc addr");
      end else begin
        chk(wb_data, ex, "data");
        chk(32'({gpr_we, fpr_we, wb_tag}), 32'({!r.fp, r.fp, 5'(i)}), "write");
        chk(seen_pa, pa, "paddr");
        chk(32'(seen_nb), 32'({r.fp, r.fp ? 2'h0 : b}), "bytes");
      end
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk(q, {25'h0, 1'b1, b, r.exc == 3'h0, r.exc}, "last");
    apb(1'b0, 12'h010, 32'h0);
    chk(q, ea, "vaddr");
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h3, "status");
    chk(32'(irq), 32'h1, "irq");
    apb(1'b1, 12'h008, 32'h0);
    @(posedge pclk);
    chk(32'(irq), 32'h0, "irq masked");
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h0, "w1c");
    apb(1'b1, 12'h008, 32'h3);
    @(posedge pclk);
    chk(32'(irq), 32'h0, "irq cleared");
    finish_test;
  end
endmodule
`default_nettype wire
